// File: smhdc_consts.vh
// constants for the smart mode host/processor control block
`ifndef SMHDC_CONSTS_VH
`define SMHDC_CONSTS_VH
// host common-memory byte offsets of the remapped block and of the signature word
`define SMHDC_OFF_RSVD0        24'h000000
`define SMHDC_OFF_CTRL         24'h000002
`define SMHDC_OFF_STATUS       24'h000004
`define SMHDC_OFF_TXMB         24'h000006
`define SMHDC_OFF_RXMB         24'h000008
`define SMHDC_OFF_RSVD_UP      24'h00000A
`define SMHDC_OFF_SIG          24'h000400
`define SMHDC_BLOCK_TOP        24'h00000F
// processor i/o space word addresses
`define SMHDC_IO_TXMB          16'h0050
`define SMHDC_IO_RXMB          16'h0051
`define SMHDC_IO_HSTAT         16'h0052
`define SMHDC_IO_BITIO         16'h0053
`define SMHDC_IO_DSP_SYSTEM_CONFIG        16'h0054
`define SMHDC_IO_BASE          16'h0050
`define SMHDC_IO_TOP           16'h005F
// attribute-memory configuration option location and mode bit
`define SMHDC_CFG_OPT_ADDR     24'h000010
`define SMHDC_CFG_MODE_BIT     5
// reset values
`define SMHDC_CTRL_RST         16'h0108
`define SMHDC_MB_RST           16'h0000
`define SMHDC_DSP_SYSTEM_CONFIG_RST       16'h0080
`define SMHDC_BITIO_RST        8'h00
// host control register bit positions
`define SMHDC_CTL_RUN          0
`define SMHDC_CTL_CLKON        1
`define SMHDC_CTL_CLKMODE      2
`define SMHDC_CTL_MICRO        3
`define SMHDC_CTL_MODE         4
`define SMHDC_CTL_IRQEN        5
`define SMHDC_CTL_IRQCLR       6
`define SMHDC_CTL_HOLDREQ      7
// host status bit positions
`define SMHDC_ST_FEIRQ         0
`define SMHDC_ST_TXFULL        1
`define SMHDC_ST_RXFULL        2
`define SMHDC_ST_HOLD_ACKNOWLEDGE         3
`define SMHDC_ST_SMART         4
`define SMHDC_ST_IRQ           5
// signature stream
`define SMHDC_SIG_COUNT        3'd4
`endif

// File: smhdc_control.v
// smart mode host/processor control and register bank
`include "smhdc_consts.vh"

module smhdc_control #(
    parameter DW = 16,
    parameter AW = 24,
    // signature word; this value is arbitrary
    parameter [15:0] SIG_PATTERN = 16'h5C3E
) (
    // clock and reset
    input  wire          core_clk,
    input  wire          sys_rst,
    // host common memory access (one-cycle strobes)
    input  wire [AW-1:0] host_addr,
    input  wire [DW-1:0] host_wdata,
    input  wire          host_mem_wr,
    input  wire          host_mem_rd,
    output reg  [DW-1:0] host_rdata,
    output wire          host_reg_hit,
    output wire          mem_pass_wr,
    output wire          mem_pass_rd,
    // host i/o port access to mailboxes
    input  wire          host_io_en,
    input  wire          host_io_sel_rx,
    input  wire          host_io_wr,
    input  wire          host_io_rd,
    // host attribute-memory configuration write
    input  wire          host_attr_wr,
    input  wire [AW-1:0] host_attr_addr,
    input  wire [7:0]    host_attr_wdata,
    // host interrupt request
    output wire          host_irq,
    // processor i/o space access
    input  wire [15:0]   proc_io_addr,
    input  wire [DW-1:0] proc_io_wdata,
    input  wire          proc_io_wr,
    input  wire          proc_io_rd,
    output reg  [DW-1:0] proc_io_rdata,
    // processor control
    output wire          proc_reset_n,
    output wire          proc_clk_en,
    output wire          proc_clk_mode,
    output wire          micro_mode_select,
    output wire          proc_hold_req,
    input  wire          hold_acknowledge_n,
    output wire          hold_acknowledge_n_force,
    output wire [DW-1:0] sys_config,
    output wire          smart_mode,
    // front end
    input  wire          analog_front_end_irq,
    input  wire          external_interrupt_four,
    output wire [7:0]    front_end_out,
    input  wire [3:0]    front_end_in
);

    reg  [DW-1:0] host_dsp_control;
    reg  [DW-1:0] dsp_to_host_mailbox;
    reg  [DW-1:0] host_to_dsp_mailbox;
    reg  [DW-1:0] dsp_system_config;
    reg  [7:0]    bitio_out;
    reg  [2:0]    sig_count;
    reg           cfg_mode;
    reg           tx_full;
    reg           rx_full;
    reg           irq_flag;
    reg           smart_q;
    reg  [DW-1:0] next_host_rdata;
    reg  [DW-1:0] next_proc_rdata;

    wire mode_bit = host_dsp_control[`SMHDC_CTL_MODE];

    // effective mode
    assign smart_mode = mode_bit | cfg_mode;

    // register block decode, used by more than one path
    function in_block;
        input [AW-1:0] a;
        begin
            in_block = (a <= `SMHDC_BLOCK_TOP);
        end
    endfunction

    function [3:0] word_sel;
        input [AW-1:0] a;
        begin
            word_sel = {1'b0, a[3:1]};
        end
    endfunction

    wire blk = smart_mode & in_block(host_addr);
    assign host_reg_hit = blk & (host_mem_wr | host_mem_rd);
    // block accesses never go to memory nor arbitrate the bus
    assign mem_pass_wr  = host_mem_wr & ~blk;
    assign mem_pass_rd  = host_mem_rd & ~blk;

    wire h_wr_ctrl = host_mem_wr & blk & (word_sel(host_addr) == 4'd1);
    wire h_rd_tx   = (host_mem_rd & blk & (word_sel(host_addr) == 4'd3)) |
                     (host_io_en & host_io_rd & ~host_io_sel_rx);
    wire h_wr_rx   = (host_mem_wr & blk & (word_sel(host_addr) == 4'd4)) |
                     (host_io_en & host_io_wr & host_io_sel_rx);
    wire p_in      = smart_mode & (proc_io_addr >= `SMHDC_IO_BASE) &
                     (proc_io_addr <= `SMHDC_IO_TOP);
    wire p_wr_tx   = p_in & proc_io_wr & (proc_io_addr == `SMHDC_IO_TXMB);
    wire p_rd_rx   = p_in & proc_io_rd & (proc_io_addr == `SMHDC_IO_RXMB);
    wire p_wr_bio  = p_in & proc_io_wr & (proc_io_addr == `SMHDC_IO_BITIO);
    wire p_wr_cfg  = p_in & proc_io_wr & (proc_io_addr == `SMHDC_IO_DSP_SYSTEM_CONFIG);

    // signature stream monitor, standard mode only
    wire sig_hit   = (host_addr == `SMHDC_OFF_SIG);
    wire sig_match = host_mem_wr & sig_hit & (host_wdata == SIG_PATTERN);
    wire sig_done  = ~smart_mode & sig_match & (sig_count == `SMHDC_SIG_COUNT - 3'd1);

    wire fe_irq = analog_front_end_irq | external_interrupt_four;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sig_count <= 3'd0;
        end else if (smart_mode) begin
            sig_count <= 3'd0;
        end else if (sig_done) begin
            sig_count <= 3'd0;
        end else if (sig_match) begin
            sig_count <= sig_count + 3'd1;
        end else if (host_mem_rd | host_mem_wr) begin
            sig_count <= 3'd0;
        end
    end

    // attribute-memory configuration mode bit
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_mode <= 1'b0;
        end else if (host_attr_wr && host_attr_addr == `SMHDC_CFG_OPT_ADDR) begin
            cfg_mode <= host_attr_wdata[`SMHDC_CFG_MODE_BIT];
        end
    end

    // host control register
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_dsp_control <= `SMHDC_CTRL_RST;
        end else if (sig_done) begin
            host_dsp_control[`SMHDC_CTL_MODE] <= 1'b1;
        end else if (smart_q & ~smart_mode) begin
            // falling back to standard forces the processor back into reset
            host_dsp_control[`SMHDC_CTL_RUN] <= 1'b0;
        end else if (h_wr_ctrl) begin
            host_dsp_control <= host_wdata;
            host_dsp_control[`SMHDC_CTL_IRQCLR] <= 1'b0;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            smart_q <= 1'b0;
        end else begin
            smart_q <= smart_mode;
        end
    end

    // mailboxes with full flags; set wins over clear
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dsp_to_host_mailbox <= `SMHDC_MB_RST;
            host_to_dsp_mailbox <= `SMHDC_MB_RST;
            tx_full             <= 1'b0;
            rx_full             <= 1'b0;
        end else begin
            if (p_wr_tx) begin
                dsp_to_host_mailbox <= proc_io_wdata;
            end
            if (h_wr_rx) begin
                host_to_dsp_mailbox <= host_wdata;
            end
            if (p_wr_tx) begin
                tx_full <= 1'b1;
            end else if (h_rd_tx) begin
                tx_full <= 1'b0;
            end
            if (h_wr_rx) begin
                rx_full <= 1'b1;
            end else if (p_rd_rx) begin
                rx_full <= 1'b0;
            end
        end
    end

    // processor-only registers
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dsp_system_config <= `SMHDC_DSP_SYSTEM_CONFIG_RST;
            bitio_out         <= `SMHDC_BITIO_RST;
        end else begin
            if (p_wr_cfg) begin
                dsp_system_config <= proc_io_wdata;
            end
            if (p_wr_bio) begin
                bitio_out <= proc_io_wdata[15:8];
            end
        end
    end

    // sticky card interrupt: event set wins over clear
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_flag <= 1'b0;
        end else if (fe_irq) begin
            irq_flag <= 1'b1;
        end else if (h_wr_ctrl & host_wdata[`SMHDC_CTL_IRQCLR]) begin
            irq_flag <= 1'b0;
        end
    end

    assign host_irq = irq_flag & host_dsp_control[`SMHDC_CTL_IRQEN];

    // processor control outputs; standard mode overrides reset, clock enable, hold request and hold force, not clock mode or micro select
    assign proc_reset_n      = smart_mode & host_dsp_control[`SMHDC_CTL_RUN];
    assign proc_clk_en       = smart_mode & host_dsp_control[`SMHDC_CTL_CLKON];
    assign proc_clk_mode     = host_dsp_control[`SMHDC_CTL_CLKMODE];
    assign micro_mode_select = host_dsp_control[`SMHDC_CTL_MICRO];
    assign proc_hold_req     = smart_mode & host_dsp_control[`SMHDC_CTL_HOLDREQ];
    assign hold_acknowledge_n_force = smart_mode;
    assign sys_config        = dsp_system_config;
    assign front_end_out     = bitio_out;

    wire [DW-1:0] status_word = {10'h000, irq_flag, smart_mode, ~hold_acknowledge_n,
                                 rx_full, tx_full, fe_irq};

    // host read mux: private and reserved words read zero
    always @* begin
        next_host_rdata = 16'h0000;
        if (host_io_en & host_io_rd & ~host_io_sel_rx) begin
            next_host_rdata = dsp_to_host_mailbox;
        end else if (blk) begin
            case (word_sel(host_addr))
                4'd1:    next_host_rdata = host_dsp_control;
                4'd2:    next_host_rdata = status_word;
                4'd3:    next_host_rdata = dsp_to_host_mailbox;
                default: next_host_rdata = 16'h0000;
            endcase
        end
    end

    // processor read mux
    always @* begin
        next_proc_rdata = 16'h0000;
        if (p_in) begin
            case (proc_io_addr)
                `SMHDC_IO_RXMB:   next_proc_rdata = host_to_dsp_mailbox;
                `SMHDC_IO_HSTAT:  next_proc_rdata = {14'h0000, rx_full, tx_full};
                `SMHDC_IO_BITIO:  next_proc_rdata = {bitio_out, 4'h0, front_end_in};
                `SMHDC_IO_DSP_SYSTEM_CONFIG: next_proc_rdata = dsp_system_config;
                default:          next_proc_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata    <= 16'h0000;
            proc_io_rdata <= 16'h0000;
        end else begin
            if (host_mem_rd | host_io_rd) begin
                host_rdata <= next_host_rdata;
            end
            if (proc_io_rd) begin
                proc_io_rdata <= next_proc_rdata;
            end
        end
    end

endmodule

// File: smhdc_chk.sv
// port-level assertions for the smart mode control block
module smhdc_chk #(
    // signature word; this value is arbitrary
    parameter [15:0] SIG_PATTERN = 16'h5C3E
) (
    // clock and reset
    input wire        core_clk,
    input wire        sys_rst,
    // host side
    input wire [23:0] host_addr,
    input wire [15:0] host_wdata,
    input wire        host_mem_wr,
    input wire        host_mem_rd,
    input wire        host_reg_hit,
    input wire        mem_pass_wr,
    input wire        mem_pass_rd,
    input wire        host_attr_wr,
    input wire [23:0] host_attr_addr,
    input wire [7:0]  host_attr_wdata,
    // processor side
    input wire        proc_io_rd,
    input wire [15:0] proc_io_rdata,
    input wire        proc_reset_n,
    input wire        proc_clk_en,
    input wire        hold_acknowledge_n_force,
    input wire        smart_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire sig_wr = host_mem_wr && host_addr == 24'h000400 && host_wdata == SIG_PATTERN;
    wire blk = smart_mode && host_addr <= 24'h00000F;
    a_std_proc_off: assert property (!smart_mode |-> !proc_reset_n && !proc_clk_en
        && !hold_acknowledge_n_force) else $error("processor active in standard mode");
    a_std_no_hit: assert property (!smart_mode |-> !host_reg_hit)
        else $error("register hit in standard mode");
    a_blk_no_mem: assert property (host_reg_hit |-> !mem_pass_wr && !mem_pass_rd)
        else $error("block access reached memory");
    a_blk_hit: assert property ((host_mem_wr || host_mem_rd) && blk |-> host_reg_hit)
        else $error("block access missed registers");
    a_wr_pass: assert property (host_mem_wr && !blk |-> mem_pass_wr)
        else $error("memory write not forwarded");
    a_rd_pass: assert property (host_mem_rd && !blk |-> mem_pass_rd)
        else $error("memory read not forwarded");
    a_sig_enter: assert property (!smart_mode && sig_wr ##1 sig_wr [*3] |=> smart_mode)
        else $error("signature did not enter smart mode");
    a_cfg_enter: assert property (host_attr_wr && host_attr_addr == 24'h000010
        && host_attr_wdata[5] |=> smart_mode) else $error("config bit did not enter smart mode");
    a_std_io_zero: assert property (!smart_mode && proc_io_rd |=> proc_io_rdata == 16'h0000)
        else $error("processor read nonzero in standard mode");
endmodule

// File: smhdc_host.sv
// host-side bus model driving the card's memory, i/o and config strobes
module smhdc_host (
    // clock and read data
    input  wire         core_clk,
    input  wire  [15:0] host_rdata,
    // strobes and qualifiers
    output logic [23:0] host_addr,
    output logic [15:0] host_wdata,
    output logic        host_mem_wr,
    output logic        host_mem_rd,
    output logic        host_io_en,
    output logic        host_io_sel_rx,
    output logic        host_io_wr,
    output logic        host_io_rd,
    output logic        host_attr_wr,
    output logic [23:0] host_attr_addr,
    output logic [7:0]  host_attr_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {host_addr, host_wdata, host_attr_addr, host_attr_wdata} = '0;
        {host_mem_wr, host_mem_rd, host_io_en, host_io_sel_rx} = '0;
        {host_io_wr, host_io_rd, host_attr_wr} = '0;
    end
    // n back-to-back word writes, one per cycle; released lines show the inverse
    task automatic mem_wr(input logic [23:0] a, input logic [15:0] d, input int n);
        @(posedge core_clk);
        #1;
        host_addr = a;
        host_wdata = d;
        host_mem_wr = 1'b1;
        repeat (n) @(posedge core_clk);
        #1;
        host_mem_wr = 1'b0;
        host_addr = ~a;
        host_wdata = ~d;
    endtask
    task automatic mem_rd(input logic [23:0] a, output logic [15:0] q);
        @(posedge core_clk);
        #1;
        host_addr = a;
        host_mem_rd = 1'b1;
        @(posedge core_clk);
        #1;
        host_mem_rd = 1'b0;
        host_addr = ~a;
        q = host_rdata;
    endtask
    task automatic io_rd(input logic rx, output logic [15:0] q);
        @(posedge core_clk);
        #1;
        host_io_en = 1'b1;
        host_io_sel_rx = rx;
        host_io_rd = 1'b1;
        @(posedge core_clk);
        #1;
        host_io_rd = 1'b0;
        q = host_rdata;
    endtask
    task automatic attr_wr(input logic [7:0] d);
        @(posedge core_clk);
        #1;
        host_attr_addr = 24'h000010;
        host_attr_wdata = d;
        host_attr_wr = 1'b1;
        @(posedge core_clk);
        #1;
        host_attr_wr = 1'b0;
        host_attr_wdata = ~d;
    endtask
endmodule

// File: smhdc_tb.sv
// self-checking bench for the smart mode control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, sys_rst, proc_io_wr, proc_io_rd, hold_acknowledge_n;
    logic        analog_front_end_irq, external_interrupt_four;
    logic [15:0] proc_io_addr, proc_io_wdata, q;
    logic [3:0]  front_end_in;
    wire  [23:0] host_addr, host_attr_addr;
    wire  [15:0] host_wdata, host_rdata, proc_io_rdata, sys_config;
    wire  [7:0]  host_attr_wdata, front_end_out;
    wire host_mem_wr, host_mem_rd, host_reg_hit, mem_pass_wr, mem_pass_rd, host_io_en;
    wire host_io_sel_rx, host_io_wr, host_io_rd, host_attr_wr, host_irq, proc_reset_n;
    wire proc_clk_en, proc_clk_mode, micro_mode_select, proc_hold_req;
    wire hold_acknowledge_n_force, smart_mode;
    int num_errors = 0;
    int num_checks = 0;
    // signature word, arbitrary, matches the design default
    localparam logic [15:0] SIG = 16'h5C3E;
    smhdc_control smhdc_control_inst (.core_clk, .sys_rst, .host_addr, .host_wdata,
        .host_mem_wr, .host_mem_rd, .host_rdata, .host_reg_hit, .mem_pass_wr, .mem_pass_rd,
        .host_io_en, .host_io_sel_rx, .host_io_wr, .host_io_rd, .host_attr_wr,
        .host_attr_addr, .host_attr_wdata, .host_irq, .proc_io_addr, .proc_io_wdata,
        .proc_io_wr, .proc_io_rd, .proc_io_rdata, .proc_reset_n, .proc_clk_en, .proc_clk_mode,
        .micro_mode_select, .proc_hold_req, .hold_acknowledge_n, .hold_acknowledge_n_force,
        .sys_config, .smart_mode, .analog_front_end_irq, .external_interrupt_four,
        .front_end_out, .front_end_in);
    smhdc_host host (.core_clk, .host_rdata, .host_addr, .host_wdata, .host_mem_wr,
        .host_mem_rd, .host_io_en, .host_io_sel_rx, .host_io_wr, .host_io_rd, .host_attr_wr,
        .host_attr_addr, .host_attr_wdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic p_acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        proc_io_addr = a;
        proc_io_wdata = d;
        proc_io_wr = wr;
        proc_io_rd = !wr;
        @(posedge core_clk);
        #1;
        {proc_io_wr, proc_io_rd} = 2'b00;
        proc_io_wdata = ~d;
        q = proc_io_rdata;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #50us;
        num_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        {sys_rst, proc_io_wr, proc_io_rd, analog_front_end_irq, external_interrupt_four} = 5'h10;
        {proc_io_addr, proc_io_wdata, front_end_in, hold_acknowledge_n} = {36'h0, 1'b1};
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        chk({smart_mode, proc_reset_n, proc_clk_en}, 16'h0000);
        // broken streams: a read, another address, another value
        host.mem_wr(24'h000400, SIG, 1);
        host.mem_rd(24'h000010, q);
        host.mem_wr(24'h000400, SIG, 3);
        chk(smart_mode, 16'h0000);
        host.mem_rd(24'h000010, q);
        host.mem_wr(24'h000400, SIG, 2);
        host.mem_wr(24'h000012, 16'h0001, 1);
        host.mem_wr(24'h000400, SIG, 2);
        chk(smart_mode, 16'h0000);
        host.mem_wr(24'h000400, 16'h1234, 1);
        host.mem_wr(24'h000400, SIG, 3);
        chk(smart_mode, 16'h0000);
        host.mem_rd(24'h000010, q);
        host.mem_wr(24'h000400, SIG, 4);
        chk(smart_mode, 16'h0001);
        host.mem_rd(24'h000002, q);
        chk(q, 16'h0118);
        $display("signature test done");
        for (int a = 0; a < 16; a += 2) if (a == 0 || a >= 10) begin
            host.mem_wr(a, 16'hFFFF, 1);
            host.mem_rd(a, q);
            chk(q, 16'h0000);
        end
        p_acc(1'b0, 16'h0054, 0);
        chk(q, 16'h0080);
        host.mem_rd(24'h000006, q);
        chk(q, 16'h0000);
        p_acc(1'b1, 16'h0050, 16'h5A5A);
        host.mem_wr(24'h000006, 16'h1111, 1);
        host.mem_rd(24'h000004, q);
        chk(q[1], 16'h0001);
        host.io_rd(1'b0, q);
        chk(q, 16'h5A5A);
        host.mem_rd(24'h000004, q);
        chk(q[1], 16'h0000);
        host.mem_wr(24'h000008, 16'hC3C3, 1);
        host.mem_rd(24'h000008, q);
        chk(q, 16'h0000);
        p_acc(1'b0, 16'h0052, 0);
        chk(q[1], 16'h0001);
        p_acc(1'b0, 16'h0051, 0);
        chk(q, 16'hC3C3);
        $display("mailbox test done");
        front_end_in = 4'h9;
        p_acc(1'b1, 16'h0053, 16'hA5FF);
        chk(front_end_out, 16'h00A5);
        p_acc(1'b0, 16'h0053, 0);
        chk({q[15:8], q[3:0]}, 16'h0A59);
        analog_front_end_irq = 1'b1;
        host.mem_wr(24'h000002, 16'h0138, 1);
        chk(host_irq, 16'h0001);
        host.mem_rd(24'h000004, q);
        chk(q[5:0], 16'h0031);
        analog_front_end_irq = 1'b0;
        hold_acknowledge_n = 1'b0;
        host.mem_wr(24'h000002, 16'h0178, 1);
        chk(host_irq, 16'h0000);
        host.mem_rd(24'h000004, q);
        chk(q[5:0], 16'h0018);
        host.mem_wr(24'h000002, 16'h011A, 1);
        chk({proc_clk_en, proc_reset_n}, 16'h0002);
        host.mem_wr(24'h000002, 16'h011B, 1);
        chk({proc_clk_en, proc_reset_n}, 16'h0003);
        $display("control test done");
        host.mem_wr(24'h000002, 16'h0108, 1);
        chk({smart_mode, proc_reset_n}, 16'h0000);
        p_acc(1'b0, 16'h0054, 0);
        chk(q, 16'h0000);
        host.attr_wr(8'h20);
        chk(smart_mode, 16'h0001);
        host.mem_wr(24'h000400, SIG, 4);
        host.mem_rd(24'h000002, q);
        chk(q, 16'h0108);
        host.attr_wr(8'h00);
        chk(smart_mode, 16'h0000);
        $display("mode test done");
        complete_run();
    end
endmodule
bind smhdc_control smhdc_chk smhdc_chk_inst (.core_clk, .sys_rst, .host_addr, .host_wdata,
    .host_mem_wr, .host_mem_rd, .host_reg_hit, .mem_pass_wr, .mem_pass_rd, .host_attr_wr,
    .host_attr_addr, .host_attr_wdata, .proc_io_rd, .proc_io_rdata, .proc_reset_n,
    .proc_clk_en, .hold_acknowledge_n_force, .smart_mode);
